// >>> pdl_consts.vh
// Constants for the synthesizer digital core: word layout, select codes,
// monitor codes and lock timing. Included by every design file.
`ifndef PDL_CONSTS_VH
`define PDL_CONSTS_VH
`define PDL_WORD_W 24
`define PDL_SEL_REF 2'h0
`define PDL_SEL_FB 2'h1
`define PDL_SEL_FUNC 2'h2
`define PDL_SEL_INIT 2'h3
`define PDL_REF_DIV_LSB 2
`define PDL_REF_DIV_MSB 15
`define PDL_BACKLASH_LSB 16
`define PDL_BACKLASH_MSB 17
`define PDL_TEST_LSB 18
`define PDL_TEST_MSB 19
`define PDL_LOCK_PREC_BIT 20
`define PDL_FB_DIV_LSB 8
`define PDL_FB_DIV_MSB 20
`define PDL_PUMP_GAIN_BIT 21
`define PDL_CLEAR_BIT 2
`define PDL_SLEEP_A_BIT 3
`define PDL_MON_LSB 4
`define PDL_MON_MSB 6
`define PDL_POLARITY_BIT 7
`define PDL_TRISTATE_BIT 8
`define PDL_RAPID_EN_BIT 9
`define PDL_RAPID_VAR_BIT 10
`define PDL_TIMEOUT_LSB 11
`define PDL_TIMEOUT_MSB 14
`define PDL_CUR_A_LSB 15
`define PDL_CUR_A_MSB 17
`define PDL_CUR_B_LSB 18
`define PDL_CUR_B_MSB 20
`define PDL_SLEEP_B_BIT 21
`define PDL_MON_TRISTATE 3'h0
`define PDL_MON_DLOCK 3'h1
`define PDL_MON_FB_DIV 3'h2
`define PDL_MON_HIGH 3'h3
`define PDL_MON_REF_DIV 3'h4
`define PDL_MON_ALOCK 3'h5
`define PDL_MON_SDATA 3'h6
`define PDL_MON_LOW 3'h7
`define PDL_CLK_NS 5
`define PDL_LOCK_SET_NS 15
`define PDL_LOCK_LOSE_NS 25
`define PDL_LOCK_SET_CYC ((`PDL_LOCK_SET_NS - 1) / `PDL_CLK_NS)
`define PDL_LOCK_LOSE_CYC (`PDL_LOCK_LOSE_NS / `PDL_CLK_NS)
`define PDL_LOCK_CNT_LO 3
`define PDL_LOCK_CNT_HI 5
`endif

// >>> pdl_core.v
// Digital core of a phase/frequency synthesizer: serial word intake, four
// configuration latches, reference and feedback dividers, phase detector,
// monitor multiplexer and lock indication.
// Assumes serial pins, load strobe, chip enable and the two input clocks are
// asynchronous and much slower than mclk_in; all are sampled by two flops.
`timescale 1ns/100ps
`include "pdl_consts.vh"
module pdl_core #(
   parameter REF_W = 14,
   parameter FB_W = 13
) (
   input wire mclk_in,
   input wire reset_n_in,
   input wire sclk_in,
   input wire sdata_in,
   input wire load_strobe_in,
   input wire chip_en_in,
   input wire ref_clk_in,
   input wire rf_clk_in,
   output reg pump_up_out,
   output reg pump_down_out,
   output reg pump_oe_out,
   output reg monitor_out,
   output reg monitor_oe_out,
   output reg lock_out,
   output reg pump_gain_out,
   output reg [2:0] pump_current_a_out,
   output reg [2:0] pump_current_b_out,
   output reg [3:0] timeout_code_out,
   output reg rapid_lock_en_out,
   output reg rapid_lock_variant_out
);
   // Two-flop synchronisers for every asynchronous input
   reg [5:0] sync_a;
   reg [5:0] sync_b;
   reg [5:0] sync_d;
   always @(posedge mclk_in) begin
      if (!reset_n_in) begin
         sync_a <= 6'h00;
         sync_b <= 6'h00;
         sync_d <= 6'h00;
      end else begin
         sync_a <= {rf_clk_in, ref_clk_in, chip_en_in, load_strobe_in, sdata_in, sclk_in};
         sync_b <= sync_a;
         sync_d <= sync_b;
      end
   end

   wire sclk_rise = sync_b[0] & ~sync_d[0];
   wire sdata_s = sync_b[1];
   wire load_rise = sync_b[2] & ~sync_d[2];
   wire chip_en_s = sync_b[3];
   wire ref_tick = sync_b[4] & ~sync_d[4];
   wire rf_tick = sync_b[5] & ~sync_d[5];

   // Shift register keeps working during power-down so words are never lost
   reg [23:0] shift_word;
   always @(posedge mclk_in) begin
      if (!reset_n_in)
         shift_word <= 24'h000000;
      else if (sclk_rise)
         shift_word <= {shift_word[22:0], sdata_s};
   end

   // Four latches, each written only by its own select code
   reg [23:0] ref_divider_word;
   reg [23:0] feedback_divider_word;
   reg [23:0] function_config_word;
   reg [23:0] init_config_word;
   always @(posedge mclk_in) begin
      if (!reset_n_in) begin
         ref_divider_word <= 24'h000004;
         feedback_divider_word <= 24'h000100;
         function_config_word <= 24'h000000;
         init_config_word <= 24'h000000;
      end else if (load_rise) begin
         case (shift_word[1:0])
            `PDL_SEL_REF: ref_divider_word <= shift_word;
            `PDL_SEL_FB: feedback_divider_word <= shift_word;
            `PDL_SEL_FUNC: function_config_word <= shift_word;
            default: init_config_word <= shift_word;
         endcase
      end
   end

   // The most recent of function and init word governs; both share one layout
   reg use_init;
   always @(posedge mclk_in) begin
      if (!reset_n_in)
         use_init <= 1'b0;
      else if (load_rise && shift_word[1])
         use_init <= shift_word[0];
   end
   wire [23:0] cfg = use_init ? init_config_word : function_config_word;

   // Field extraction
   wire [REF_W-1:0] ref_ratio = ref_divider_word[`PDL_REF_DIV_MSB:`PDL_REF_DIV_LSB];
   wire [1:0] backlash_width = ref_divider_word[`PDL_BACKLASH_MSB:`PDL_BACKLASH_LSB];
   wire lock_precision_sel = ref_divider_word[`PDL_LOCK_PREC_BIT];
   wire [FB_W-1:0] fb_ratio = feedback_divider_word[`PDL_FB_DIV_MSB:`PDL_FB_DIV_LSB];
   wire pump_gain_sel = feedback_divider_word[`PDL_PUMP_GAIN_BIT];
   wire count_clear = cfg[`PDL_CLEAR_BIT];
   wire sleep_ctrl_a = cfg[`PDL_SLEEP_A_BIT];
   wire [2:0] monitor_sel = cfg[`PDL_MON_MSB:`PDL_MON_LSB];
   wire detector_polarity = cfg[`PDL_POLARITY_BIT];
   wire pump_tristate = cfg[`PDL_TRISTATE_BIT];
   wire sleep_ctrl_b = cfg[`PDL_SLEEP_B_BIT];

   // Synchronous sleep waits for a detector event; asynchronous is at once
   reg sync_sleep;
   reg cmp_evt;
   always @(posedge mclk_in) begin
      if (!reset_n_in)
         sync_sleep <= 1'b0;
      else if (!(sleep_ctrl_a && sleep_ctrl_b))
         sync_sleep <= 1'b0;
      else if (cmp_evt)
         sync_sleep <= 1'b1;
   end
   wire power_down = !chip_en_s || (sleep_ctrl_a && !sleep_ctrl_b) || sync_sleep;
   wire div_hold = power_down || count_clear;

   // Dividers; releasing both on one cycle keeps them closely aligned
   wire ref_pulse;
   wire fb_pulse;
   pdl_divider #(.W(REF_W)) u_ref_div (
      .mclk_in(mclk_in),
      .reset_n_in(reset_n_in),
      .hold_in(div_hold),
      .tick_in(ref_tick),
      .ratio_in(ref_ratio),
      .pulse_out(ref_pulse)
   );
   pdl_divider #(.W(FB_W)) u_fb_div (
      .mclk_in(mclk_in),
      .reset_n_in(reset_n_in),
      .hold_in(div_hold),
      .tick_in(rf_tick),
      .ratio_in(fb_ratio),
      .pulse_out(fb_pulse)
   );

   // Phase detector state; polarity swaps the two inputs
   reg up_req;
   reg dn_req;
   reg [7:0] err_cnt;
   reg [7:0] err_last;
   reg err_done;
   reg [2:0] blp_cnt;
   wire ref_in = detector_polarity ? ref_pulse : fb_pulse;
   wire fb_in = detector_polarity ? fb_pulse : ref_pulse;
   wire next_up = up_req | ref_in;
   wire next_dn = dn_req | fb_in;
   // Backlash width in clocks; code 0 is the narrowest
   wire [2:0] blp_len = {1'b0, backlash_width} + 3'h1;

   // Both requests high means the comparison is done; hold overlap then reset
   always @(posedge mclk_in) begin
      if (!reset_n_in || power_down) begin
         up_req <= 1'b0;
         dn_req <= 1'b0;
         err_cnt <= 8'h00;
         err_last <= 8'h00;
         err_done <= 1'b0;
         blp_cnt <= 3'h0;
         cmp_evt <= 1'b0;
      end else begin
         err_done <= 1'b0;
         cmp_evt <= 1'b0;
         if (blp_cnt != 3'h0) begin
            blp_cnt <= blp_cnt - 3'h1;
            if (blp_cnt == 3'h1) begin
               up_req <= 1'b0;
               dn_req <= 1'b0;
            end
         end else if (next_up && next_dn) begin
            up_req <= 1'b1;
            dn_req <= 1'b1;
            blp_cnt <= blp_len;
            err_last <= err_cnt;
            err_done <= 1'b1;
            cmp_evt <= 1'b1;
            err_cnt <= 8'h00;
         end else begin
            up_req <= next_up;
            dn_req <= next_dn;
            if ((next_up || next_dn) && err_cnt != 8'hFF)
               err_cnt <= err_cnt + 8'h01;
         end
      end
   end

   wire dlock;
   pdl_lock_detect u_lock (
      .mclk_in(mclk_in),
      .reset_n_in(reset_n_in),
      .clear_in(power_down),
      .prec_in(lock_precision_sel),
      .err_done_in(err_done),
      .err_cyc_in(err_last),
      .locked_out(dlock)
   );

   // Analog lock: low only while a request is open (open-drain pulls low)
   wire alock_low = up_req | dn_req;

   // Monitor mux and pump outputs, all registered
   always @(posedge mclk_in) begin
      if (!reset_n_in) begin
         monitor_out <= 1'b0;
         monitor_oe_out <= 1'b0;
         pump_up_out <= 1'b0;
         pump_down_out <= 1'b0;
         pump_oe_out <= 1'b0;
         lock_out <= 1'b0;
      end else begin
         case (monitor_sel)
            `PDL_MON_TRISTATE: begin
               monitor_out <= 1'b0;
               monitor_oe_out <= 1'b0;
            end
            `PDL_MON_DLOCK: begin
               monitor_out <= dlock;
               monitor_oe_out <= 1'b1;
            end
            `PDL_MON_FB_DIV: begin
               monitor_out <= fb_pulse;
               monitor_oe_out <= 1'b1;
            end
            `PDL_MON_HIGH: begin
               monitor_out <= 1'b1;
               monitor_oe_out <= 1'b1;
            end
            `PDL_MON_REF_DIV: begin
               monitor_out <= ref_pulse;
               monitor_oe_out <= 1'b1;
            end
            `PDL_MON_ALOCK: begin
               monitor_out <= 1'b0;
               monitor_oe_out <= alock_low;
            end
            `PDL_MON_SDATA: begin
               monitor_out <= sdata_s;
               monitor_oe_out <= 1'b1;
            end
            default: begin
               monitor_out <= 1'b0;
               monitor_oe_out <= 1'b1;
            end
         endcase
         // Both requests go out unmasked so the antibacklash overlap reaches the pump
         pump_up_out <= up_req;
         pump_down_out <= dn_req;
         pump_oe_out <= !(power_down || pump_tristate);
         lock_out <= dlock;
      end
   end

   // Pump and timer settings go straight out for the analog side
   always @(posedge mclk_in) begin
      if (!reset_n_in) begin
         pump_gain_out <= 1'b0;
         pump_current_a_out <= 3'h0;
         pump_current_b_out <= 3'h0;
         timeout_code_out <= 4'h0;
         rapid_lock_en_out <= 1'b0;
         rapid_lock_variant_out <= 1'b0;
      end else begin
         pump_gain_out <= pump_gain_sel;
         pump_current_a_out <= cfg[`PDL_CUR_A_MSB:`PDL_CUR_A_LSB];
         pump_current_b_out <= cfg[`PDL_CUR_B_MSB:`PDL_CUR_B_LSB];
         timeout_code_out <= cfg[`PDL_TIMEOUT_MSB:`PDL_TIMEOUT_LSB];
         rapid_lock_en_out <= cfg[`PDL_RAPID_EN_BIT];
         rapid_lock_variant_out <= cfg[`PDL_RAPID_VAR_BIT];
      end
   end
endmodule // pdl_core

// >>> pdl_core_assertions.sv
// Port-level checker for the synthesizer core.
// Assumes only top ports; latch contents are seen through the outputs.
`timescale 1ns/100ps
module pdl_core_checker (
   input wire mclk_in,
   input wire reset_n_in,
   input wire chip_en_in,
   input wire load_strobe_in,
   input wire pump_up_out,
   input wire pump_down_out,
   input wire pump_oe_out,
   input wire lock_out,
   input wire pump_gain_out,
   input wire [2:0] pump_current_a_out,
   input wire [2:0] pump_current_b_out,
   input wire [3:0] timeout_code_out,
   input wire rapid_lock_en_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);
   reg [3:0] since_ld;
   reg [2:0] n_cmp;
   reg ld_q;
   reg both_q;
   wire both = pump_up_out && pump_down_out;
   // Age of the last load and comparisons since enable; saturate so old events expire
   always @(posedge mclk_in) begin
      ld_q <= load_strobe_in;
      both_q <= both;
      if (!reset_n_in)
         since_ld <= 4'hF;
      else if (load_strobe_in && !ld_q)
         since_ld <= 4'h0;
      else if (since_ld != 4'hF)
         since_ld <= since_ld + 4'h1;
      if (!reset_n_in || !chip_en_in)
         n_cmp <= 3'h0;
      else if (both && !both_q && n_cmp != 3'h7)
         n_cmp <= n_cmp + 3'h1;
   end
   ce_pump_off_a: assert property (!chip_en_in [*5] |-> !pump_oe_out)
      else $error("pump driven while disabled");
   ce_lock_clear_a: assert property (!chip_en_in [*5] |-> !lock_out)
      else $error("lock held while disabled");
   backlash_end_a: assert property ($rose(both) |-> ##[1:4] !both)
      else $error("antibacklash pulse too long");
   lock_after_cmp_a: assert property ($rose(lock_out) |-> n_cmp >= 3'h3)
      else $error("lock before three comparisons");
   timeout_hold_a: assert property ($changed(timeout_code_out) |-> since_ld <= 4'h8)
      else $error("timeout code moved without load");
   cur_a_hold_a: assert property ($changed(pump_current_a_out) |-> since_ld <= 4'h8)
      else $error("current a moved without load");
   cur_b_hold_a: assert property ($changed(pump_current_b_out) |-> since_ld <= 4'h8)
      else $error("current b moved without load");
   gain_hold_a: assert property ($changed(pump_gain_out) |-> since_ld <= 4'h8)
      else $error("gain moved without load");
   rapid_hold_a: assert property ($changed(rapid_lock_en_out) |-> since_ld <= 4'h8)
      else $error("rapid lock moved without load");
   lock_seen_c: cover property ($rose(lock_out));
   lock_lost_c: cover property ($fell(lock_out) && chip_en_in);
   wide_pulse_c: cover property (both [*4]);
endmodule // pdl_core_checker

bind pdl_core pdl_core_checker chk (.mclk_in, .reset_n_in, .chip_en_in, .load_strobe_in,
   .pump_up_out, .pump_down_out, .pump_oe_out, .lock_out, .pump_gain_out,
   .pump_current_a_out, .pump_current_b_out, .timeout_code_out, .rapid_lock_en_out);

// >>> pdl_divider.v
// Programmable down counter that emits one pulse every 'ratio' input ticks.
// Assumes tick_in is a single-cycle enable already synchronised to mclk_in.
`timescale 1ns/100ps
`include "pdl_consts.vh"
module pdl_divider #(
   parameter W = 14
) (
   input wire mclk_in,
   input wire reset_n_in,
   input wire hold_in,
   input wire tick_in,
   input wire [W-1:0] ratio_in,
   output reg pulse_out
);
   reg [W-1:0] count;
   wire [W-1:0] eff_ratio;

   // Zero is treated as one so the counter never stalls
   assign eff_ratio = (ratio_in == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : ratio_in;

   // Count down; the new ratio is only sampled at the reload point
   always @(posedge mclk_in) begin
      if (!reset_n_in || hold_in) begin
         count <= {W{1'b0}};
         pulse_out <= 1'b0;
      end else begin
         pulse_out <= 1'b0;
         if (tick_in) begin
            if (count <= {{(W-1){1'b0}}, 1'b1}) begin
               count <= eff_ratio;
               pulse_out <= 1'b1;
            end else begin
               count <= count - {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // pdl_divider

// >>> pdl_host_model.sv
// Host side of the three-wire word intake for the synthesizer core.
// Assumes mclk_in paces the pins; each serial clock and strobe level holds 4 cycles, each data bit 8.
`timescale 1ns/100ps
module pdl_host_model (
   output reg sclk_out,
   output reg sdata_out,
   output reg load_strobe_out,
   input wire mclk_in
);
   integer i;
   // Idle: serial clock and strobe low, data line parked
   initial begin
      sclk_out = 1'h0;
      sdata_out = 1'h1;
      load_strobe_out = 1'h0;
   end
   // Shift MSB first, then raise the strobe once the last bit is in
   task send(input [23:0] w);
      begin
         for (i = 23; i >= 0; i = i - 1) begin
            sdata_out <= w[i];
            repeat (4) @(posedge mclk_in);
            sclk_out <= 1'h1;
            repeat (4) @(posedge mclk_in);
            sclk_out <= 1'h0;
         end
         load_strobe_out <= 1'h1;
         repeat (4) @(posedge mclk_in);
         load_strobe_out <= 1'h0;
         sdata_out <= ~w[0]; // Released line must not look like a held bit
         repeat (4) @(posedge mclk_in);
      end
   endtask
endmodule // pdl_host_model

// >>> pdl_lock_detect.v
// Digital lock detector: counts consecutive small-error comparisons.
// Assumes err_done_in pulses once per comparison with err_cyc_in valid.
`timescale 1ns/100ps
`include "pdl_consts.vh"
module pdl_lock_detect (
   input wire mclk_in,
   input wire reset_n_in,
   input wire clear_in,
   input wire prec_in,
   input wire err_done_in,
   input wire [7:0] err_cyc_in,
   output reg locked_out
);
   reg [2:0] good_cnt;
   wire [2:0] need;

   assign need = prec_in ? 3'h5 : 3'h3;

   // Lock sets after a run of small errors and drops on one large error
   always @(posedge mclk_in) begin
      if (!reset_n_in || clear_in) begin
         good_cnt <= 3'h0;
         locked_out <= 1'b0;
      end else if (err_done_in) begin
         if (err_cyc_in <= `PDL_LOCK_SET_CYC) begin
            if (good_cnt < need)
               good_cnt <= good_cnt + 3'h1;
            if (good_cnt + 3'h1 >= need)
               locked_out <= 1'b1;
         end else begin
            good_cnt <= 3'h0;
            if (err_cyc_in > `PDL_LOCK_LOSE_CYC)
               locked_out <= 1'b0;
         end
      end
   end
endmodule // pdl_lock_detect

// >>> test_pdl_core.sv
// Self-checking bench for pdl_core: host model loads words, bench makes
// reference and RF clocks. Assumes both clocks are slow against mclk_in.
`timescale 1ns/100ps
module test_pdl_core;
   reg mclk_in = 1'h0;
   reg reset_n_in = 1'h0;
   reg chip_en_in = 1'h0;
   reg run = 1'h0;
   reg [5:0] ph = 6'h00;
   reg [31:0] hist = 32'h0;
   integer skew = 0;
   integer fails = 0;
   integer total_checks = 0;
   integer cyc = 0;
   integer p, k, n;
   wire sclk, sdata, ld, up, dn, poe, mon, mon_oe, lock, gain, ra_en, ra_var;
   wire [2:0] cur_a, cur_b;
   wire [3:0] tmo;
   always #2.5 mclk_in = ~mclk_in;
   // Reference is a 40-cycle square wave; RF is a copy delayed by skew
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      ph <= (!run || ph == 6'h27) ? 6'h00 : ph + 6'h01;
      hist <= {hist[30:0], run && ph < 6'h14};
      if (cyc == 20000) begin
         fails = fails + 1;
         test_done;
      end
   end
   pdl_host_model host (.sclk_out(sclk), .sdata_out(sdata), .load_strobe_out(ld),
      .mclk_in(mclk_in));
   pdl_core dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .sclk_in(sclk),
      .sdata_in(sdata), .load_strobe_in(ld), .chip_en_in(chip_en_in),
      .ref_clk_in(hist[0]), .rf_clk_in(hist[skew]), .pump_up_out(up), .pump_down_out(dn),
      .pump_oe_out(poe), .monitor_out(mon), .monitor_oe_out(mon_oe), .lock_out(lock),
      .pump_gain_out(gain), .pump_current_a_out(cur_a), .pump_current_b_out(cur_b),
      .timeout_code_out(tmo), .rapid_lock_en_out(ra_en), .rapid_lock_variant_out(ra_var));
   // Word builders; reserved bits are sent as zero
   function [23:0] ref_w(input pr, input [1:0] bl);
      ref_w = {3'h0, pr, 2'h0, bl, 14'h0001, 2'h0};
   endfunction
   function [23:0] fn_w(input [1:0] s, input [3:0] t, input [2:0] a, input [2:0] b,
      input [2:0] m, input z);
      fn_w = {3'h0, b, a, t, 2'h1, z, 1'h1, m, 2'h0, s};
   endfunction
   task check(input [7:0] got, input [7:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // Outputs settle 4 cycles after the strobe, so wait 8
   task load(input [23:0] w);
      begin
         @(posedge mclk_in);
         host.send(w);
         repeat (8) @(posedge mclk_in);
      end
   endtask
   task periods(input integer c);
      repeat (c * 40) @(posedge mclk_in);
   endtask
   // Stop both clocks until the delay line is flushed, so a new skew makes no stray edge
   task set_skew(input integer s);
      begin
         run <= 1'h0;
         repeat (40) @(posedge mclk_in);
         skew <= s;
         run <= 1'h1;
      end
   endtask
   // Two whole reference periods: drive-enable cycles plus 16 per high monitor cycle
   task count_mon;
      begin
         n = 0;
         repeat (80) begin
            @(posedge mclk_in);
            #1;
            n = n + mon_oe + 16 * mon;
         end
      end
   endtask
   task test_done;
      begin
         $display("checks %0d fails %0d", total_checks, fails);
         if (fails == 0 && total_checks > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   initial begin
      repeat (3) @(posedge mclk_in);
      reset_n_in <= 1'h1;
      chip_en_in <= 1'h1;
      repeat (3) @(posedge mclk_in);
      // Function then init word drive config; divider words leave it alone
      load(fn_w(2'h2, 4'hA, 3'h5, 3'h3, 3'h1, 1'h0));
      check({ra_en, tmo, cur_a}, 8'hD5);
      check({ra_var, cur_b, poe}, 8'h07);
      load(fn_w(2'h3, 4'h5, 3'h2, 3'h6, 3'h1, 1'h1));
      check({ra_en, tmo, cur_a}, 8'hAA);
      check({ra_var, cur_b, poe}, 8'h0C);
      load(ref_w(1'h0, 2'h0));
      load({2'h0, 1'h1, 13'h0001, 8'h01});
      check({gain, tmo}, 8'h15);
      $display("config test done");
      for (k = 0; k < 3; k = k + 1) begin
         load(fn_w(2'h2, 4'h0, 3'h0, 3'h0, k == 0 ? 3'h3 : k == 1 ? 3'h7 : 3'h0, 1'h0));
         check({mon_oe, mon && mon_oe}, k == 0 ? 8'h03 : k == 1 ? 8'h02 : 8'h00);
      end
      $display("monitor test done");
      load(fn_w(2'h2, 4'h0, 3'h0, 3'h0, 3'h1, 1'h0));
      for (p = 0; p < 2; p = p + 1) begin
         load(ref_w(p[0], 2'h2));
         chip_en_in <= 1'h0;
         repeat (8) @(posedge mclk_in);
         check({lock, poe}, 8'h00);
         chip_en_in <= 1'h1;
         run <= 1'h1;
         repeat (140) @(posedge mclk_in);
         check({lock, mon}, p ? 8'h00 : 8'h03);
         periods(4);
         check({lock, mon}, 8'h03);
      end
      set_skew(5);
      periods(4);
      check(lock, 8'h01);
      set_skew(6);
      periods(2);
      check(lock, 8'h00);
      set_skew(0);
      $display("lock test done");
      for (p = 0; p < 4; p = p + 1) begin
         load(ref_w(1'h0, p[1:0]));
         periods(2);
         // Start on a quiet sample so a pulse already under way is not half counted
         @(posedge mclk_in);
         #1;
         while (up && dn) begin
            @(posedge mclk_in);
            #1;
         end
         n = 0;
         for (k = 0; k < 90 && n < 9; k = k + 1) begin
            @(posedge mclk_in);
            #1;
            if (up && dn)
               n = n + 1;
            else if (n != 0)
               k = 90;
         end
         check(n[7:0], p[7:0] + 8'h01);
      end
      $display("backlash test done");
      load(fn_w(2'h2, 4'h0, 3'h0, 3'h0, 3'h4, 1'h0) | 24'h000004);
      count_mon;
      check(n[7:0], 8'h50);
      load(fn_w(2'h2, 4'h0, 3'h0, 3'h0, 3'h4, 1'h0));
      count_mon;
      check(n[7:0], 8'h70);
      load(fn_w(2'h2, 4'h0, 3'h0, 3'h0, 3'h5, 1'h0));
      count_mon;
      check(n[7:0], 8'h08);
      $display("monitor source test done");
      test_done;
   end
endmodule // test_pdl_core
